// >>> verilog/csci_top.sv
`timescale 1ns/1ps
// Operation
// R01: flag bits 7..4 read zero, ignore writes
// R02: bit 3 sets on either detect change
// R03: flags clear by read or write-one
// R04: memory card: bit 2 on ready rise
// R05: i/o card: bits 2,1 read zero
// R06: memory card: bit 1 on battery warning
// R07: bit 0 battery dead or status signal
// R08: ring mode: bit 0 shows ring input
// R09: all flags reset to zero
// R10: route field bits 7..4, reset none
// R11: codes 4..9,12 pick matching irq
// R12: config bit 3 enables detect events
// R13: config bit 2 enables ready events
// R14: config bit 1 enables battery warning
// R15: config bit 0 enables dead/status events
// R16: disabled source flag reads zero
// R17: clear mode picked by global bit 2
// R18: override routes interrupt to pci
// R19: irq asserted while enabled flag set
module csci_top (
    input wire logic clk,
    input wire logic rst,
    input wire csci_pkg::csci_card_s card_in,
    input wire logic card_status_signal,
    input wire logic io_card_mode,
    input wire logic ring_enable,
    input wire logic clear_by_write,
    input wire logic status_irq_pci_override,
    input wire csci_pkg::csci_bus_s bus_in,
    output logic [7:0] rdata,
    output logic [15:0] irq_out,
    output logic smi_out,
    output logic pci_irq_out
);
    logic [7:0] config_reg;
    logic [7:0] config_next;
    logic [3:0] flags_reg;
    logic [3:0] flags_next;
    logic [3:0] event_set;
    logic [3:0] flag_view;
    logic [7:0] rdata_next;
    logic det_a_chg;
    logic det_b_chg;
    logic ready_rise;
    logic sts_rise;
    logic [15:0] irq_next;
    logic smi_next;
    logic pci_next;
    logic rd_flags;
    logic wr_flags;
    logic wr_config;
    csci_pkg::csci_batt_e batt_state;

    // battery voltage detect decode
    function automatic csci_pkg::csci_batt_e batt_decode(input logic bvd1, input logic bvd2);
        if (!bvd1)
            return csci_pkg::CSCI_BATT_DEAD;
        else if (!bvd2)
            return csci_pkg::CSCI_BATT_WARN;
        else
            return csci_pkg::CSCI_BATT_OK;
    endfunction

    csci_edge u_det_a (.clk(clk), .rst(rst), .level_in(card_in.card_detect_a), .rise(), .change(det_a_chg));
    csci_edge u_det_b (.clk(clk), .rst(rst), .level_in(card_in.card_detect_b), .rise(), .change(det_b_chg));
    csci_edge u_ready (.clk(clk), .rst(rst), .level_in(card_in.ready), .rise(ready_rise), .change());
    csci_edge u_sts (.clk(clk), .rst(rst), .level_in(card_status_signal), .rise(sts_rise), .change());

    // access decode
    always_comb
    begin
        rd_flags = 1'b0;
        wr_flags = 1'b0;
        wr_config = 1'b0;
        if (bus_in.addr == csci_pkg::FLAGS_OFFSET)
        begin
            rd_flags = bus_in.rd;
            wr_flags = bus_in.wr;
        end
        else if (bus_in.addr == csci_pkg::CONFIG_OFFSET)
            wr_config = bus_in.wr;
    end

    // next configuration; mask and router use it so a disable or a new route acts at once
    always_comb
    begin
        config_next = config_reg;
        if (wr_config)
            config_next = bus_in.wdata;
    end

    // configuration register
    always_ff @(posedge clk)
    begin
        if (rst)
            config_reg <= csci_pkg::CONFIG_RESET; // [R10] [R12] [R13] [R14] [R15]
        else
            config_reg <= config_next;
    end

    assign batt_state = batt_decode(card_in.bvd1, card_in.bvd2);

    // source events gated by enables
    always_comb
    begin
        event_set = 4'h0;
        event_set[csci_pkg::DETECT_BIT] = (det_a_chg | det_b_chg)
            & config_reg[csci_pkg::DETECT_BIT]; // [R02] [R12] [R16]
        event_set[csci_pkg::READY_BIT] = ready_rise & ~io_card_mode
            & config_reg[csci_pkg::READY_BIT]; // [R04] [R05] [R13]
        event_set[csci_pkg::BATLOW_BIT] = (batt_state == csci_pkg::CSCI_BATT_WARN) & ~io_card_mode
            & config_reg[csci_pkg::BATLOW_BIT]; // [R06] [R05] [R14]
        if (io_card_mode)
            event_set[csci_pkg::BATTERY_DEAD_FLAG_BIT] = sts_rise & config_reg[csci_pkg::BATTERY_DEAD_FLAG_BIT]; // [R07] [R15]
        else
            event_set[csci_pkg::BATTERY_DEAD_FLAG_BIT] = (batt_state == csci_pkg::CSCI_BATT_DEAD)
                & config_reg[csci_pkg::BATTERY_DEAD_FLAG_BIT]; // [R07] [R15]
    end

    // sticky flags: set wins over clear
    always_comb
    begin
        flags_next = flags_reg;
        if (rd_flags && !clear_by_write)
            flags_next = 4'h0; // [R03] [R17]
        else if (wr_flags && clear_by_write)
            flags_next = flags_reg & ~bus_in.wdata[3:0]; // [R03] [R17] [R01]
        flags_next = (flags_next | event_set) & config_next[3:0]; // [R16]
        if (io_card_mode)
            flags_next[2:1] = 2'b00; // [R05]
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            flags_reg <= csci_pkg::FLAGS_RESET; // [R09]
        else
            flags_reg <= flags_next;
    end

    // visible flag value; ring mode shows ring input on bit 0
    always_comb
    begin
        flag_view = flags_reg;
        if (ring_enable)
            flag_view[csci_pkg::BATTERY_DEAD_FLAG_BIT] = card_in.ring_indicate_in; // [R08]
    end

    // read data, upper flag bits zero
    always_comb
    begin
        rdata_next = 8'h00;
        if (bus_in.rd && bus_in.addr == csci_pkg::FLAGS_OFFSET)
            rdata_next = {4'h0, flag_view}; // [R01]
        else if (bus_in.rd && bus_in.addr == csci_pkg::CONFIG_OFFSET)
            rdata_next = config_reg;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= 8'h00;
        else
            rdata <= rdata_next;
    end

    csci_route u_route (
        .route_sel(config_next[7:csci_pkg::ROUTE_LSB]), // [R10] [R11]
        .pci_override(status_irq_pci_override), // [R18]
        .irq_active(|flags_next), // [R19]
        .irq_lines(irq_next),
        .smi(smi_next),
        .pci_irq(pci_next)
    );

    // registered interrupt outputs
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_out <= 16'h0000;
            smi_out <= 1'b0;
            pci_irq_out <= 1'b0;
        end
        else
        begin
            irq_out <= irq_next;
            smi_out <= smi_next;
            pci_irq_out <= pci_next;
        end
    end

    // checks
    // flags come out of reset clear
    flags_reset_a: assert property (@(posedge clk) rst |=> flags_reg == 4'h0) // [R09]
        else $error("flags not clear after reset");

    // configuration comes out of reset with routing off and every source disabled
    cfg_reset_a: assert property (@(posedge clk) rst |=> config_reg == 8'h00) // [R10]
        else $error("config not clear after reset");

    // a configuration write lands whole
    config_write_a: assert property (@(posedge clk) disable iff (rst) // [R10]
        wr_config |=> config_reg == $past(bus_in.wdata))
        else $error("config write lost");

    // an i/o card never holds the ready or battery warning flag
    io_zero_a: assert property (@(posedge clk) disable iff (rst) // [R05]
        io_card_mode |=> flags_reg[2:1] == 2'b00)
        else $error("io card bits 2,1 set");

    // a disabled source never holds its flag
    disabled_zero_a: assert property (@(posedge clk) disable iff (rst) // [R16]
        1'b1 |=> (flags_reg & ~config_reg[3:0]) == 4'h0)
        else $error("disabled flag set");

    // a change on either detect line sets the detect flag
    detect_set_a: assert property (@(posedge clk) disable iff (rst) // [R02]
        ((det_a_chg || det_b_chg) && config_reg[3] && !wr_config) |=> flags_reg[3])
        else $error("detect change lost");

    // a read in read-clear mode empties the flags
    read_clear_a: assert property (@(posedge clk) disable iff (rst) // [R03]
        (rd_flags && !clear_by_write && event_set == 4'h0 && !wr_config) |=> flags_reg == 4'h0)
        else $error("read did not clear");

    // writing ones in write-clear mode clears the flags named
    write_clear_a: assert property (@(posedge clk) disable iff (rst) // [R03]
        (wr_flags && clear_by_write && bus_in.wdata[3:0] == flags_reg && event_set == 4'h0)
        |=> flags_reg == 4'h0)
        else $error("write-one did not clear");

    // a read in write-clear mode leaves a set flag alone
    read_keep_a: assert property (@(posedge clk) disable iff (rst) // [R17]
        (rd_flags && clear_by_write && flags_reg[3]) |=> flags_reg[3])
        else $error("read cleared in write-clear mode");

    // a ready rise on a memory card sets the ready flag
    ready_set_a: assert property (@(posedge clk) disable iff (rst) // [R04]
        (ready_rise && !io_card_mode && config_reg[2] && !wr_config) |=> flags_reg[2])
        else $error("ready rise lost");

    // a battery warning on a memory card sets the warning flag
    batlow_set_a: assert property (@(posedge clk) disable iff (rst) // [R06]
        (batt_state == csci_pkg::CSCI_BATT_WARN && !io_card_mode && config_reg[1] && !wr_config)
        |=> flags_reg[1])
        else $error("battery warning lost");

    // a dead battery on a memory card sets bit 0
    dead_set_a: assert property (@(posedge clk) disable iff (rst) // [R07]
        (batt_state == csci_pkg::CSCI_BATT_DEAD && !io_card_mode && config_reg[0] && !wr_config)
        |=> flags_reg[0])
        else $error("battery dead lost");

    // a status signal rise on an i/o card sets bit 0
    status_set_a: assert property (@(posedge clk) disable iff (rst) // [R07]
        (sts_rise && io_card_mode && config_reg[0] && !wr_config) |=> flags_reg[0])
        else $error("status change lost");

    // ring mode puts the ring input on bit 0 of the read data
    ring_view_a: assert property (@(posedge clk) disable iff (rst) // [R08]
        (ring_enable && rd_flags) |=> rdata[0] == $past(card_in.ring_indicate_in))
        else $error("ring bit wrong");

    // the reserved upper flag bits always read zero
    reserved_zero_a: assert property (@(posedge clk) disable iff (rst) // [R01]
        rd_flags |=> rdata[7:4] == 4'h0)
        else $error("reserved flag bits set");

    // a pending flag drives the chosen legacy line
    irq_follow_a: assert property (@(posedge clk) disable iff (rst) // [R19]
        (flags_reg != 4'h0 && !$past(status_irq_pci_override) && config_reg[7:4] == 4'h5) |-> irq_out[5])
        else $error("irq not asserted");

    // every legacy code drives exactly its own line
    route_line_a: assert property (@(posedge clk) disable iff (rst) // [R11]
        (flags_reg != 4'h0 && !$past(status_irq_pci_override) && config_reg[7:4] != csci_pkg::ROUTE_SMI
        && config_reg[7:4] != csci_pkg::ROUTE_NONE) |-> (irq_out == (16'h0001 << config_reg[7:4]) && !smi_out))
        else $error("legacy line wrong");

    // the smi code drives smi and no legacy line
    smi_route_a: assert property (@(posedge clk) disable iff (rst) // [R10]
        (flags_reg != 4'h0 && !$past(status_irq_pci_override) && config_reg[7:4] == csci_pkg::ROUTE_SMI)
        |-> (smi_out && irq_out == 16'h0000))
        else $error("smi route wrong");

    // no pending flag leaves every interrupt output low
    irq_idle_a: assert property (@(posedge clk) disable iff (rst) // [R19]
        (flags_reg == 4'h0) |-> (irq_out == 16'h0000 && !smi_out && !pci_irq_out))
        else $error("interrupt without flag");

    // override keeps the legacy lines and smi quiet
    pci_route_a: assert property (@(posedge clk) disable iff (rst) // [R18]
        status_irq_pci_override |=> irq_out == 16'h0000 && !smi_out)
        else $error("legacy irq under override");

    // override sends a pending flag to the pci line
    pci_level_a: assert property (@(posedge clk) disable iff (rst) // [R18]
        (flags_reg != 4'h0 && $past(status_irq_pci_override)) |-> pci_irq_out)
        else $error("pci irq not asserted");

    // main scenarios reached
    detect_cov: cover property (@(posedge clk) disable iff (rst) det_a_chg && config_reg[3]);
    smi_cov: cover property (@(posedge clk) disable iff (rst) smi_out);
    w1c_cov: cover property (@(posedge clk) disable iff (rst) wr_flags && clear_by_write && flags_reg != 4'h0);
    status_cov: cover property (@(posedge clk) disable iff (rst) sts_rise && io_card_mode && config_reg[0]);
    pci_cov: cover property (@(posedge clk) disable iff (rst) pci_irq_out);
endmodule // csci_top

// >>> verilog/csci_pkg.sv
package csci_pkg;
    // register indexes within the socket register block
    localparam logic [11:0] FLAGS_OFFSET = 12'h804;
    localparam logic [11:0] CONFIG_OFFSET = 12'h805;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    // flag and enable bit positions, route field low bit
    localparam int DETECT_BIT = 3;
    localparam int READY_BIT = 2;
    localparam int BATLOW_BIT = 1;
    localparam int BATTERY_DEAD_FLAG_BIT = 0;
    localparam int ROUTE_LSB = 4;
    // route codes
    localparam logic [3:0] ROUTE_NONE = 4'h0;
    localparam logic [3:0] ROUTE_SMI = 4'h2;

    typedef enum logic [1:0] {
        CSCI_BATT_OK = 2'b00,
        CSCI_BATT_WARN = 2'b01,
        CSCI_BATT_DEAD = 2'b10
    } csci_batt_e;

    // card-side sampled inputs
    typedef struct packed {
        logic card_detect_a;
        logic card_detect_b;
        logic ready;
        logic bvd1;
        logic bvd2;
        logic ring_indicate_in;
    } csci_card_s;

    // host register access strobe bundle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } csci_bus_s;
endpackage

// >>> verilog/csci_edge.sv
`timescale 1ns/1ps
// registers a level and reports its rise and any change
module csci_edge (
    input wire logic clk,
    input wire logic rst,
    input wire logic level_in,
    output logic rise,
    output logic change
);
    logic prev_reg;

    // previous value, reset to current level is not allowed so reset low
    always_ff @(posedge clk)
    begin
        if (rst)
            prev_reg <= 1'b0;
        else
            prev_reg <= level_in;
    end

    assign rise = level_in & ~prev_reg;
    assign change = level_in ^ prev_reg;
endmodule // csci_edge

// >>> verilog/csci_route.sv
`timescale 1ns/1ps
// decodes the route field into one-hot legacy lines and smi
module csci_route (
    input wire logic [3:0] route_sel,
    input wire logic pci_override,
    input wire logic irq_active,
    output logic [15:0] irq_lines,
    output logic smi,
    output logic pci_irq
);
    // code n selects irq n, except code 0 which selects none and code 2 which selects smi
    always_comb
    begin
        irq_lines = 16'h0000;
        smi = 1'b0;
        pci_irq = 1'b0;
        if (pci_override)
            pci_irq = irq_active;
        else if (route_sel == csci_pkg::ROUTE_SMI)
            smi = irq_active;
        else if (route_sel != csci_pkg::ROUTE_NONE)
            irq_lines[route_sel] = irq_active;
    end
endmodule // csci_route

// >>> verif/csci_card_model.sv
`timescale 1ns/1ps
// card in the socket: requested pin levels show one clock later
module csci_card_model (
    input wire logic clk,
    input wire logic det_lvl,
    input wire logic det_b_lvl,
    input wire logic ready_lvl,
    input wire csci_pkg::csci_batt_e batt,
    input wire logic ring_lvl,
    input wire logic sts_lvl,
    output csci_pkg::csci_card_s card,
    output logic sts_pin
);
    // battery code drives both voltage detect pins
    always_ff @(posedge clk)
    begin
        card <= '{det_lvl, det_b_lvl, ready_lvl, batt != csci_pkg::CSCI_BATT_DEAD,
            batt == csci_pkg::CSCI_BATT_OK, ring_lvl};
        sts_pin <= sts_lvl;
    end
endmodule // csci_card_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [11:0] FLG = csci_pkg::FLAGS_OFFSET;
    localparam logic [11:0] CFG = csci_pkg::CONFIG_OFFSET;
    typedef struct packed {logic [7:0] cfg; logic io; logic [2:0] kind; logic [7:0] flags;} csci_row_s;
    logic clk, rst, io, ring_en, cbw, ovr, det, det_b, rdy, ring, sts, sts_pin, smi, pci;
    csci_pkg::csci_batt_e batt;
    csci_pkg::csci_card_s card;
    csci_pkg::csci_bus_s bus;
    logic [7:0] rdata;
    logic [15:0] irq;
    int mismatches = 0;
    int total_checks = 0;
    // route, card type, event kind, flags read back
    csci_row_s rows [14] = '{'{8'h58, 1'b0, 3'h0, 8'h08}, '{8'h14, 1'b0, 3'h1, 8'h04},
        '{8'h42, 1'b0, 3'h2, 8'h02}, '{8'hf1, 1'b0, 3'h3, 8'h01}, '{8'h71, 1'b1, 3'h4, 8'h01},
        '{8'h24, 1'b1, 3'h1, 8'h00}, '{8'h62, 1'b1, 3'h2, 8'h00}, '{8'h20, 1'b0, 3'h0, 8'h00},
        '{8'h21, 1'b0, 3'h3, 8'h01}, '{8'h84, 1'b0, 3'h1, 8'h04}, '{8'h98, 1'b0, 3'h0, 8'h08},
        '{8'hc8, 1'b0, 3'h0, 8'h08}, '{8'h38, 1'b0, 3'h5, 8'h08}, '{8'hd8, 1'b0, 3'h5, 8'h08}};

    csci_card_model card_model (.clk(clk), .det_lvl(det), .det_b_lvl(det_b), .ready_lvl(rdy), .batt(batt),
        .ring_lvl(ring), .sts_lvl(sts), .card(card), .sts_pin(sts_pin));
    csci_top DUT (.clk(clk), .rst(rst), .card_in(card), .card_status_signal(sts_pin),
        .io_card_mode(io), .ring_enable(ring_en), .clear_by_write(cbw),
        .status_irq_pci_override(ovr), .bus_in(bus), .rdata(rdata), .irq_out(irq),
        .smi_out(smi), .pci_irq_out(pci));

    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #2;
        end
    endtask

    // one bus cycle; a read is checked in the cycle its data stands
    task automatic acc(input logic r, input logic [11:0] a, input logic [7:0] d, input logic [7:0] exp);
        bus <= '{r, ~r, a, d};
        cyc(1);
        if (r)
            check({10'h000, rdata}, {10'h000, exp});
        bus <= '0;
        cyc(1);
    endtask

    // one card event, then the card returns to idle
    task automatic ev(input logic [2:0] k);
        case (k)
            3'h0: det <= ~det;
            3'h1: rdy <= 1'b1;
            3'h2: batt <= csci_pkg::CSCI_BATT_WARN;
            3'h3: batt <= csci_pkg::CSCI_BATT_DEAD;
            3'h5: det_b <= ~det_b;
            default: sts <= 1'b1;
        endcase
        cyc(1);
        rdy <= 1'b0;
        batt <= csci_pkg::CSCI_BATT_OK;
        sts <= 1'b0;
        cyc(3);
    endtask

    // expected smi and legacy lines from route code and pending event
    function automatic logic [17:0] exp_irq(input logic [3:0] n, input logic act);
        exp_irq = '0;
        if (act && n == 4'h2)
            exp_irq[16] = 1'b1;
        else if (act && n != 4'h0)
            exp_irq[n] = 1'b1;
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {rst, io, ring_en, cbw, ovr, det, rdy, ring, sts} = 9'h100;
        batt = csci_pkg::CSCI_BATT_OK;
        det_b = 1'b0;
        bus = '0;
        cyc(4);
        rst <= 1'b0;
        cyc(1);
        foreach (rows[i])
        begin
            io <= rows[i].io;
            acc(1'b0, CFG, rows[i].cfg, 8'h00);
            ev(rows[i].kind);
            check({pci, smi, irq}, exp_irq(rows[i].cfg[7:4], rows[i].flags != 8'h00));
            acc(1'b1, FLG, 8'h00, rows[i].flags);
            acc(1'b1, FLG, 8'h00, 8'h00);
            check({pci, smi, irq}, 18'h00000);
            $display("row %0d done", i);
        end
        // register reset values, reserved bits, unmapped read, mid-run reset
        acc(1'b1, CFG, 8'h00, 8'hd8);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        acc(1'b1, CFG, 8'h00, 8'h00);
        acc(1'b1, FLG, 8'h00, 8'h00);
        acc(1'b1, 12'h806, 8'h00, 8'h00);
        $display("reset test done");
        // write-one clear mode: read keeps flag, high nibble write ignored
        cbw <= 1'b1;
        acc(1'b0, CFG, 8'h58, 8'h00);
        ev(3'h0);
        acc(1'b1, FLG, 8'h00, 8'h08);
        acc(1'b1, FLG, 8'h00, 8'h08);
        acc(1'b0, FLG, 8'hf0, 8'h00);
        acc(1'b1, FLG, 8'h00, 8'h08);
        acc(1'b0, FLG, 8'hf8, 8'h00);
        acc(1'b1, FLG, 8'h00, 8'h00);
        cbw <= 1'b0;
        $display("clear mode test done");
        // disabling a source drops its flag and the interrupt
        ev(3'h0);
        acc(1'b0, CFG, 8'h50, 8'h00);
        check({pci, smi, irq}, 18'h00000);
        acc(1'b1, FLG, 8'h00, 8'h00);
        // ring mode shows the ring input on bit 0
        ring_en <= 1'b1;
        ring <= 1'b1;
        acc(1'b0, CFG, 8'h01, 8'h00);
        cyc(2);
        acc(1'b1, FLG, 8'h00, 8'h01);
        ring <= 1'b0;
        cyc(2);
        acc(1'b1, FLG, 8'h00, 8'h00);
        ring_en <= 1'b0;
        $display("disable and ring test done");
        // override sends the event to the pci line only
        ovr <= 1'b1;
        acc(1'b0, CFG, 8'h58, 8'h00);
        ev(3'h0);
        check({pci, smi, irq}, 18'h20000);
        acc(1'b1, FLG, 8'h00, 8'h08);
        check({pci, smi, irq}, 18'h00000);
        $display("override test done");
        complete_run();
    end
endmodule // tb_top
